// *** pkg/gsc_consts.vh ***
// Constants for the gyro sensor core: offsets, fields, reset values, timing
`ifndef GSC_CONSTS_VH
`define GSC_CONSTS_VH

// Reset value of the upper six bits of the 7-bit slave address (identity register is writable)
`define GSC_ADDR_HI       6'h34

// Register offsets
`define GSC_REG_IDENT     8'h00
`define GSC_REG_SMPL_DIV  8'h15
`define GSC_REG_FILT      8'h16
`define GSC_REG_INT_CFG   8'h17
`define GSC_REG_INT_STAT  8'h1A
`define GSC_REG_TEMP_H    8'h1B
`define GSC_REG_TEMP_L    8'h1C
`define GSC_REG_X_H       8'h1D
`define GSC_REG_X_L       8'h1E
`define GSC_REG_Y_H       8'h1F
`define GSC_REG_Y_L       8'h20
`define GSC_REG_Z_H       8'h21
`define GSC_REG_Z_L       8'h22
`define GSC_REG_CLK_SEL   8'h3E

// Interrupt configuration field positions
`define GSC_IC_ACT_LOW    7
`define GSC_IC_OPEN_DRN   6
`define GSC_IC_LATCH      5
`define GSC_IC_ANY_RD_CLR 4
`define GSC_IC_CLK_RDY_EN 2
`define GSC_IC_RAW_RDY_EN 0

// Interrupt status field positions
`define GSC_IS_CLK_RDY    2
`define GSC_IS_RAW_RDY    0

// Filter register: filter config [2:0], full-scale [4:3]
`define GSC_FILT_CFG_MSB  2
`define GSC_FS_FIXED      2'h3

// Reset values
`define GSC_RST_SMPL_DIV  8'h00
`define GSC_RST_FILT      3'h0
`define GSC_RST_INT_CFG   8'h00
`define GSC_RST_CLK_SEL   3'h0
`define GSC_CLK_SEL_MAX   3'h5

// Timing
`define GSC_CLK_HZ        100000000
`define GSC_CLK_NS        10
`define GSC_FAST_RATE_HZ  8000
`define GSC_SLOW_RATE_HZ  1000
`define GSC_INT_PULSE_NS  50000

`endif

// *** rtl/gsc_sync.v ***
// Two-flop level synchroniser for signals entering the core clock domain
`timescale 1ns/1ps
module gsc_sync #(
   parameter RST_VAL = 1'b0
) (
   input  wire i_clk,     // Core clock
   input  wire i_rst_n,   // Synchronous reset, active low
   input  wire i_async,   // Level from outside the domain
   output reg  o_sync     // Synchronised level
);
   reg meta_r;

   // The first stage feeds only the second stage
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         meta_r <= RST_VAL;
         o_sync <= RST_VAL;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

// *** rtl/gsc_core.v ***
// Gyro sensor digital core: serial slave port, registers, clock select, interrupt
`timescale 1ns/1ps
`include "gsc_consts.vh"

// Functional notes
// - The core is only ever a slave on the two-wire bus.
// - Slave address resets to 110100 plus the address-select pin level as LSB.
// - The identity register at address 0 holds the bus address.
// - After reset the internal source clocks the logic until a new reference is selected and the PLL locks.
// - Selectable references: relaxation oscillator or X, Y, Z drive oscillators.
// - External 32.768 kHz or 19.2 MHz reference may also be selected.
// - Output rate runs from 8000 down to 3.9 samples per second.
// - Interrupt may be raised when the PLL locks after a source switch.
// - Interrupt may be raised when a new sample set is available.
// - Interrupt config sets pin behaviour, latching, clearing and enables.
// - Interrupt pin is push-pull or open-drain by configuration.
// - Pending interrupt conditions are readable in a status register.
// - Data registers hold latest results and are readable at any time.
// - Data registers ignore writes from the bus.
// - Each gyro axis gives its own 16-bit sample.
// - Full-scale range is fixed at plus or minus 2000 degrees per second.
// - Die temperature result sits beside the gyro samples.
// - Burst writes store successive bytes at incrementing addresses.
// - Acknowledged burst reads return successive registers.
module gsc_core #(
   parameter integer FAST_CYC  = `GSC_CLK_HZ / `GSC_FAST_RATE_HZ,  // Cycles per fast base tick
   parameter integer SLOW_CYC  = `GSC_CLK_HZ / `GSC_SLOW_RATE_HZ,  // Cycles per slow base tick
   parameter integer PULSE_CYC = `GSC_INT_PULSE_NS / `GSC_CLK_NS   // Unlatched interrupt pulse
) (
   input  wire        i_clk,          // 100 MHz core clock
   input  wire        i_rst_n,        // Synchronous reset, active low
   input  wire        i_scl,          // Serial clock pin
   input  wire        i_sda,          // Serial data pin level
   output wire        o_sda_o,        // Serial data drive value (always low)
   output wire        o_sda_oe,       // Serial data pull-down enable
   input  wire        i_addr_sel,     // Address-select pin
   input  wire        i_pll_lock,     // PLL lock from analog clock generator
   output reg  [2:0]  o_pll_ref_sel,  // Reference the PLL is asked to lock to
   output reg  [2:0]  o_sys_clk_sel,  // Reference currently clocking the system
   output reg  [2:0]  o_filt_cfg,     // Low-pass filter setting to the front end
   input  wire [15:0] i_gyro_x,       // X converter result
   input  wire [15:0] i_gyro_y,       // Y converter result
   input  wire [15:0] i_gyro_z,       // Z converter result
   input  wire [15:0] i_temp,         // Temperature converter result
   output reg         o_sample_stb,   // Pulse when a sample set is captured
   output reg         o_int_o,        // Interrupt pin drive value
   output reg         o_int_oe        // Interrupt pin drive enable
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_RX   = 5'h02;
   localparam [4:0] S_ACK  = 5'h04;
   localparam [4:0] S_TX   = 5'h08;
   localparam [4:0] S_MACK = 5'h10;

   wire        scl_s;
   wire        sda_s;
   wire        asel_s;
   wire        lock_s;
   reg         scl_d_r;
   reg         sda_d_r;
   reg  [4:0]  state_r;
   reg  [3:0]  bit_cnt_r;
   reg  [7:0]  shift_r;
   reg  [7:0]  ptr_r;
   reg         is_addr_r;
   reg         have_ptr_r;
   reg         rw_r;
   reg         sda_oe_r;
   reg  [5:0]  ident_r;
   reg  [7:0]  smpl_div_r;
   reg  [7:0]  int_cfg_r;
   reg  [15:0] x_r;
   reg  [15:0] y_r;
   reg  [15:0] z_r;
   reg  [15:0] t_r;
   reg         sw_pend_r;
   reg  [17:0] base_cnt_r;
   reg  [7:0]  div_cnt_r;
   reg         stat_raw_r;
   reg         stat_clk_r;
   reg  [15:0] pulse_cnt_r;
   reg  [7:0]  rd_data;

   // Lines from pins and the analog clock generator are asynchronous
   gsc_sync #(.RST_VAL(1'b1)) u_sync_scl (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_async(i_scl), .o_sync(scl_s));
   gsc_sync #(.RST_VAL(1'b1)) u_sync_sda (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_async(i_sda), .o_sync(sda_s));
   gsc_sync #(.RST_VAL(1'b0)) u_sync_asel (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_async(i_addr_sel), .o_sync(asel_s));
   gsc_sync #(.RST_VAL(1'b0)) u_sync_lock (.i_clk(i_clk), .i_rst_n(i_rst_n),
      .i_async(i_pll_lock), .o_sync(lock_s));

   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;
   wire byte_done = (state_r == S_RX) & scl_fall & (bit_cnt_r == 4'h8);
   wire addr_hit  = (shift_r[7:1] == {ident_r, asel_s});
   wire wr_en     = byte_done & ~is_addr_r & have_ptr_r;
   wire rd_en     = ((state_r == S_ACK) & rw_r & scl_fall) | ((state_r == S_MACK) & scl_fall);

   always @* begin
      case (ptr_r)
         `GSC_REG_IDENT:    rd_data = {1'b0, ident_r, asel_s};
         `GSC_REG_SMPL_DIV: rd_data = smpl_div_r;
         `GSC_REG_FILT:     rd_data = {3'h0, `GSC_FS_FIXED, o_filt_cfg};
         `GSC_REG_INT_CFG:  rd_data = int_cfg_r;
         `GSC_REG_INT_STAT: rd_data = {5'h00, stat_clk_r, 1'b0, stat_raw_r};
         `GSC_REG_TEMP_H:   rd_data = t_r[15:8];
         `GSC_REG_TEMP_L:   rd_data = t_r[7:0];
         `GSC_REG_X_H:      rd_data = x_r[15:8];
         `GSC_REG_X_L:      rd_data = x_r[7:0];
         `GSC_REG_Y_H:      rd_data = y_r[15:8];
         `GSC_REG_Y_L:      rd_data = y_r[7:0];
         `GSC_REG_Z_H:      rd_data = z_r[15:8];
         `GSC_REG_Z_L:      rd_data = z_r[7:0];
         `GSC_REG_CLK_SEL:  rd_data = {5'h00, o_pll_ref_sel};
         default:           rd_data = 8'h00;
      endcase
   end

   // slave-only: never drives the clock, only pulls data low
   assign o_sda_o  = 1'b0;
   assign o_sda_oe = sda_oe_r;

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         scl_d_r    <= 1'b1;
         sda_d_r    <= 1'b1;
         state_r    <= S_IDLE;
         bit_cnt_r  <= 4'h0;
         shift_r    <= 8'h00;
         ptr_r      <= 8'h00;
         is_addr_r  <= 1'b0;
         have_ptr_r <= 1'b0;
         rw_r       <= 1'b0;
         sda_oe_r   <= 1'b0;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
         if (bus_start) begin
            state_r   <= S_RX;
            bit_cnt_r <= 4'h0;
            is_addr_r <= 1'b1;
            sda_oe_r  <= 1'b0;
         end else if (bus_stop) begin
            state_r  <= S_IDLE;
            sda_oe_r <= 1'b0;
         end else begin
            case (state_r)
               S_IDLE: begin
                  sda_oe_r <= 1'b0;
               end
               S_RX: begin
                  if (scl_rise) begin
                     shift_r   <= {shift_r[6:0], sda_s};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (byte_done) begin
                     bit_cnt_r <= 4'h0;
                     if (is_addr_r) begin
                        if (addr_hit) begin
                           state_r   <= S_ACK;
                           sda_oe_r  <= 1'b1;
                           rw_r      <= shift_r[0];
                           is_addr_r <= 1'b0;
                           if (!shift_r[0]) begin
                              have_ptr_r <= 1'b0;
                           end
                        end else begin
                           // Not our address: stay off the bus until the next start
                           state_r <= S_IDLE;
                        end
                     end else begin
                        state_r  <= S_ACK;
                        sda_oe_r <= 1'b1;
                        if (!have_ptr_r) begin
                           ptr_r      <= shift_r;
                           have_ptr_r <= 1'b1;
                        end else begin
                           ptr_r <= ptr_r + 8'h01;
                        end
                     end
                  end
               end
               S_ACK: begin
                  if (scl_fall) begin
                     if (rw_r) begin
                        state_r   <= S_TX;
                        shift_r   <= rd_data;
                        sda_oe_r  <= ~rd_data[7];
                        bit_cnt_r <= 4'h1;
                     end else begin
                        state_r  <= S_RX;
                        sda_oe_r <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (scl_fall) begin
                     if (bit_cnt_r == 4'h8) begin
                        state_r  <= S_MACK;
                        sda_oe_r <= 1'b0;
                     end else begin
                        sda_oe_r  <= ~shift_r[6];
                        shift_r   <= {shift_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               S_MACK: begin
                  if (scl_rise) begin
                     if (sda_s) begin
                        state_r <= S_IDLE;
                     end else begin
                        ptr_r <= ptr_r + 8'h01;
                     end
                  end else if (scl_fall) begin
                     state_r   <= S_TX;
                     shift_r   <= rd_data;
                     sda_oe_r  <= ~rd_data[7];
                     bit_cnt_r <= 4'h1;
                  end
               end
               default: begin
                  state_r  <= S_IDLE;
                  sda_oe_r <= 1'b0;
               end
            endcase
         end
      end
   end

   // Writable configuration registers; data and status offsets ignore writes
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         ident_r       <= `GSC_ADDR_HI;
         smpl_div_r    <= `GSC_RST_SMPL_DIV;
         o_filt_cfg    <= `GSC_RST_FILT;
         int_cfg_r     <= `GSC_RST_INT_CFG;
         o_pll_ref_sel <= `GSC_RST_CLK_SEL;
         sw_pend_r     <= 1'b0;
      end else begin
         if (wr_en) begin
            case (ptr_r)
               `GSC_REG_IDENT:    ident_r    <= shift_r[6:1];
               `GSC_REG_SMPL_DIV: smpl_div_r <= shift_r;
               `GSC_REG_FILT:     o_filt_cfg <= shift_r[`GSC_FILT_CFG_MSB:0];
               `GSC_REG_INT_CFG:  int_cfg_r  <= shift_r;
               default:           ident_r    <= ident_r;
            endcase
         end
         // reference request; codes above the table are refused
         if (wr_en && ptr_r == `GSC_REG_CLK_SEL && shift_r[2:0] <= `GSC_CLK_SEL_MAX
             && shift_r[2:0] != o_pll_ref_sel) begin
            o_pll_ref_sel <= shift_r[2:0];
            sw_pend_r     <= 1'b1;
         end else if (sw_pend_r && lock_s) begin
            sw_pend_r <= 1'b0;
         end
      end
   end

   wire clk_switch = sw_pend_r & lock_s;

   // stay on the old source until lock
   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_sys_clk_sel <= `GSC_RST_CLK_SEL;
      end else if (clk_switch) begin
         o_sys_clk_sel <= o_pll_ref_sel;
      end
   end

   // base tick 8 kHz unfiltered, else 1 kHz; divided by divider+1
   wire [17:0] base_top  = (o_filt_cfg == 3'h0) ? FAST_CYC[17:0] - 18'h1 : SLOW_CYC[17:0] - 18'h1;
   wire        base_tick = (base_cnt_r >= base_top);
   wire        smpl_tick = base_tick & (div_cnt_r >= smpl_div_r);

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         base_cnt_r   <= 18'h0;
         div_cnt_r    <= 8'h00;
         o_sample_stb <= 1'b0;
         x_r          <= 16'h0000;
         y_r          <= 16'h0000;
         z_r          <= 16'h0000;
         t_r          <= 16'h0000;
      end else begin
         base_cnt_r   <= base_tick ? 18'h0 : base_cnt_r + 18'h1;
         o_sample_stb <= smpl_tick;
         if (base_tick) begin
            div_cnt_r <= smpl_tick ? 8'h00 : div_cnt_r + 8'h01;
         end
         if (smpl_tick) begin
            x_r <= i_gyro_x;
            y_r <= i_gyro_y;
            z_r <= i_gyro_z;
            t_r <= i_temp;
         end
      end
   end

   // Status flags: a set in the same cycle as a clear wins
   wire stat_clr = rd_en & (int_cfg_r[`GSC_IC_ANY_RD_CLR] | (ptr_r == `GSC_REG_INT_STAT));
   wire ev_raw   = o_sample_stb & int_cfg_r[`GSC_IC_RAW_RDY_EN];
   wire ev_clk   = clk_switch & int_cfg_r[`GSC_IC_CLK_RDY_EN];
   wire int_lat  = (stat_raw_r & int_cfg_r[`GSC_IC_RAW_RDY_EN])
                 | (stat_clk_r & int_cfg_r[`GSC_IC_CLK_RDY_EN]);
   wire int_act  = int_cfg_r[`GSC_IC_LATCH] ? int_lat : (pulse_cnt_r != 16'h0);
   wire pin_lvl  = int_cfg_r[`GSC_IC_ACT_LOW] ? ~int_act : int_act;

   always @(posedge i_clk) begin
      if (!i_rst_n) begin
         stat_raw_r  <= 1'b0;
         stat_clk_r  <= 1'b0;
         pulse_cnt_r <= 16'h0;
         o_int_o     <= 1'b0;
         o_int_oe    <= 1'b1;
      end else begin
         stat_raw_r <= o_sample_stb | (stat_raw_r & ~stat_clr);
         stat_clk_r <= clk_switch | (stat_clk_r & ~stat_clr);
         // Unlatched mode: fixed-width pulse, retriggered by each enabled event
         if (ev_raw | ev_clk) begin
            pulse_cnt_r <= PULSE_CYC[15:0];
         end else if (pulse_cnt_r != 16'h0) begin
            pulse_cnt_r <= pulse_cnt_r - 16'h1;
         end
         // open-drain drives only the low level
         o_int_o  <= pin_lvl;
         o_int_oe <= int_cfg_r[`GSC_IC_OPEN_DRN] ? ~pin_lvl : 1'b1;
      end
   end
endmodule

// *** tb/gsc_core_chk.sv ***
// Port-level assertions for the gyro sensor core
`timescale 1ns/1ps
module gsc_core_chk #(
   parameter integer FAST_CYC = 20
) (
   input wire logic       i_clk,          // Core clock
   input wire logic       i_rst_n,        // Sync reset, low
   input wire logic       i_scl,          // Bus clock pin
   input wire logic       i_pll_lock,     // PLL lock
   input wire logic       o_sda_o,        // Data drive value
   input wire logic       o_sda_oe,       // Data pull-down
   input wire logic [2:0] o_pll_ref_sel,  // Requested reference
   input wire logic [2:0] o_sys_clk_sel,  // Reference in use
   input wire logic [2:0] o_filt_cfg,     // Filter setting
   input wire logic       o_sample_stb    // Capture pulse
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   logic [31:0] gap_r;
   logic        seen_r;
   logic [2:0]  filt_r;
   // Gap restarts on a filter change, since the tick base may restart then
   always @(posedge i_clk) begin
      filt_r <= o_filt_cfg;
      if (!i_rst_n || o_filt_cfg != filt_r) begin
         seen_r <= 1'b0;
         gap_r  <= 32'h0;
      end else if (o_sample_stb) begin
         seen_r <= 1'b1;
         gap_r  <= 32'h0;
      end else if (gap_r < 32'hFFFF) begin
         gap_r <= gap_r + 32'h1;
      end
   end
   sequence s_lock_low;
      !i_pll_lock [*6];
   endsequence
   property p_sda_o_low; o_sda_o == 1'b0; endproperty
   property p_sda_scl_low; $changed(o_sda_oe) |-> !i_scl; endproperty
   property p_stb_pulse; o_sample_stb |=> !o_sample_stb; endproperty
   property p_stb_gap; o_sample_stb && seen_r |-> gap_r >= FAST_CYC - 1; endproperty
   property p_ref_range; o_pll_ref_sel <= 3'h5; endproperty
   property p_ref_scl; $changed(o_pll_ref_sel) |-> !i_scl; endproperty
   property p_filt_scl; $changed(o_filt_cfg) |-> !i_scl; endproperty
   property p_sys_match; $changed(o_sys_clk_sel) |-> o_sys_clk_sel == o_pll_ref_sel; endproperty
   property p_sys_hold; s_lock_low |=> $stable(o_sys_clk_sel); endproperty
   a_sda_o_low: assert property (p_sda_o_low)
      else $error("data line driven high");
   a_sda_scl_low: assert property (p_sda_scl_low)
      else $error("data drive moved while bus clock high");
   a_stb_pulse: assert property (p_stb_pulse)
      else $error("capture strobe longer than one cycle");
   a_stb_gap: assert property (p_stb_gap)
      else $error("captures closer than one base tick");
   a_ref_range: assert property (p_ref_range)
      else $error("reserved clock code accepted");
   a_ref_scl: assert property (p_ref_scl)
      else $error("reference select moved outside a write");
   a_filt_scl: assert property (p_filt_scl)
      else $error("filter setting moved outside a write");
   a_sys_match: assert property (p_sys_match)
      else $error("system clock moved to an unrequested source");
   a_sys_hold: assert property (p_sys_hold)
      else $error("system clock switched without lock");
endmodule
bind gsc_core gsc_core_chk #(.FAST_CYC(FAST_CYC)) i_gsc_core_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_pll_lock(i_pll_lock),
   .o_sda_o(o_sda_o), .o_sda_oe(o_sda_oe), .o_pll_ref_sel(o_pll_ref_sel),
   .o_sys_clk_sel(o_sys_clk_sel), .o_filt_cfg(o_filt_cfg), .o_sample_stb(o_sample_stb));

// *** tb/gsc_i2c_master.sv ***
// Bus master model standing in for the system processor
`timescale 1ns/1ps
module gsc_i2c_master (
   input  wire logic i_clk,  // Core clock
   input  wire logic i_sda,  // Resolved data line
   output logic      o_scl,  // Serial clock
   output logic      o_sda   // Data drive, 1 releases
);
   logic [7:0] rd_q [0:11];
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic bit_x(input logic b, output logic r);
      tick(30);
      o_sda <= b;
      tick(100);
      o_scl <= 1'b1;
      tick(60);
      r = i_sda;
      tick(60);
      o_scl <= 1'b0;
   endtask
   // Serves as start and as repeated start
   task automatic start_c;
      tick(30);
      o_sda <= 1'b1;
      tick(100);
      o_scl <= 1'b1;
      tick(60);
      o_sda <= 1'b0;
      tick(60);
      o_scl <= 1'b0;
   endtask
   task automatic byte_x(input logic [7:0] d, input logic ak, output logic [7:0] q,
                         output logic got);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
      bit_x(ak, r);
      got = !r;
   endtask
   // Address only when nw and nr are both zero
   task automatic xact(input logic [6:0] ad, input logic [7:0] ra, input logic [7:0] wd [0:2],
                       input int nw, input int nr, output logic ok);
      logic [7:0] q;
      logic       a;
      start_c();
      byte_x({ad, 1'b0}, 1'b1, q, ok);
      if (nw + nr > 0) byte_x(ra, 1'b1, q, a);
      if (nw + nr > 0) ok &= a;
      for (int i = 0; i < nw; i++) byte_x(wd[i], 1'b1, q, a);
      if (nr > 0) begin
         start_c();
         byte_x({ad, 1'b1}, 1'b1, q, a);
         ok &= a;
         for (int i = 0; i < nr; i++) byte_x(8'hFF, i == nr - 1, rd_q[i], a);
      end
      tick(30);
      o_sda <= 1'b0;
      tick(100);
      o_scl <= 1'b1;
      tick(60);
      o_sda <= 1'b1;
      tick(70);
   endtask
endmodule

// *** tb/gyro_sensor_i2c_core_tb_top.sv ***
// Self-checking bench for the gyro sensor core
`timescale 1ns/1ps
`include "gsc_consts.vh"
module gyro_sensor_i2c_core_tb_top;
   localparam int SLOW = 40;
   logic        clk, rst_n, addr_sel, lock, ok;
   logic [15:0] gx, gy, gz, tmp;
   wire         scl, m_sda, sda_o, sda_oe, stb, int_o, int_oe;
   wire  [2:0]  ref_sel, sys_sel, filt;
   wire         sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
   int          num_errors, n_tests, cyc, n;
   gsc_core #(.FAST_CYC(20), .SLOW_CYC(SLOW), .PULSE_CYC(8)) i_gsc_core (
      .i_clk(clk), .i_rst_n(rst_n), .i_scl(scl), .i_sda(sda_w), .o_sda_o(sda_o),
      .o_sda_oe(sda_oe), .i_addr_sel(addr_sel), .i_pll_lock(lock), .o_pll_ref_sel(ref_sel),
      .o_sys_clk_sel(sys_sel), .o_filt_cfg(filt), .i_gyro_x(gx), .i_gyro_y(gy),
      .i_gyro_z(gz), .i_temp(tmp), .o_sample_stb(stb), .o_int_o(int_o), .o_int_oe(int_oe));
   gsc_i2c_master i_gsc_i2c_master (.i_clk(clk), .i_sda(sda_w), .o_scl(scl), .o_sda(m_sda));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic test_done;
      if (num_errors == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Ceiling above the expected run of about 94.2k cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 99000) begin
         num_errors++;
         test_done();
      end
   end
   task automatic wait_stb;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (stb !== 1'b1 && n < 2000);
   endtask
   task automatic wr(input logic [7:0] ra, input logic [7:0] a, b, c, input int nw);
      i_gsc_i2c_master.xact({`GSC_ADDR_HI, 1'b1}, ra, '{a, b, c}, nw, 0, ok);
   endtask
   task automatic t_ident;
      i_gsc_i2c_master.xact(7'h69, 8'h00, '{8'h0, 8'h0, 8'h0}, 0, 0, ok);
      chk(ok, 1'b0);
      i_gsc_i2c_master.xact(7'h68, 8'h00, '{8'h0, 8'h0, 8'h0}, 0, 0, ok);
      chk(ok, 1'b1);
      addr_sel <= 1'b1;
      repeat (10) @(posedge clk);
      i_gsc_i2c_master.xact(7'h68, 8'h00, '{8'h0, 8'h0, 8'h0}, 0, 0, ok);
      chk(ok, 1'b0);
      i_gsc_i2c_master.xact(7'h69, `GSC_REG_IDENT, '{8'h0, 8'h0, 8'h0}, 0, 1, ok);
      chk(ok, 1'b1);
      chk(i_gsc_i2c_master.rd_q[0], {1'b0, `GSC_ADDR_HI, 1'b1});
   endtask
   // Unlatched, active high, push-pull, both triggers enabled
   task automatic t_config;
      wr(`GSC_REG_SMPL_DIV, 8'h01, 8'h02, 8'h05, 3);
      chk(ok, 1'b1);
      chk(filt, 3'h2);
      wait_stb();
      wait_stb();
      chk(n, 2 * SLOW);
      chk(int_oe, 1'b1);
      // Pulse of 8 cycles follows the strobe, well before the next one
      repeat (3) @(posedge clk);
      chk(int_o, 1'b1);
      repeat (20) @(posedge clk);
      chk(int_o, 1'b0);
   endtask
   task automatic t_clock;
      chk(sys_sel, 3'h0);
      // One axis oscillator, both external references and a refused code
      for (int c = 3; c <= 6; c++) begin
         wr(`GSC_REG_CLK_SEL, c[7:0], 8'h0, 8'h0, 1);
         repeat (5) @(posedge clk);
         chk(ref_sel, (c > 5) ? 3'h5 : c[2:0]);
         chk(sys_sel, 3'h0);
      end
      lock <= 1'b1;
      repeat (10) @(posedge clk);
      chk(sys_sel, 3'h5);
   endtask
   task automatic t_data;
      tmp <= 16'h1234;
      gx  <= 16'h8001;
      gy  <= 16'h7FFE;
      gz  <= 16'hFFFF;
      wait_stb();
      wait_stb();
      i_gsc_i2c_master.xact(7'h69, `GSC_REG_INT_STAT, '{8'h0, 8'h0, 8'h0}, 0, 9, ok);
      chk(i_gsc_i2c_master.rd_q[0], 8'h05);
      chk({i_gsc_i2c_master.rd_q[1], i_gsc_i2c_master.rd_q[2]}, 16'h1234);
      chk({i_gsc_i2c_master.rd_q[3], i_gsc_i2c_master.rd_q[4]}, 16'h8001);
      chk({i_gsc_i2c_master.rd_q[5], i_gsc_i2c_master.rd_q[6]}, 16'h7FFE);
      chk({i_gsc_i2c_master.rd_q[7], i_gsc_i2c_master.rd_q[8]}, 16'hFFFF);
      wr(`GSC_REG_INT_CFG, 8'hE5, 8'h0, 8'h0, 1);
      repeat (3) @(posedge clk);
      chk({int_o, int_oe}, 2'b01);
   endtask
   initial begin
      rst_n    = 1'b0;
      addr_sel = 1'b0;
      lock     = 1'b0;
      gx       = 16'h0;
      gy       = 16'h0;
      gz       = 16'h0;
      tmp      = 16'h0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (5) @(posedge clk);
      t_ident();
      t_config();
      t_clock();
      t_data();
      test_done();
   end
endmodule
